// *** dac_port_pkg.sv ***
// package: pin timing constants, command and pin bundles for the dac latch port host
package dac_port_pkg;
	localparam int CLOCK_PERIOD_NS = 5;
	localparam int STROBE_LOW_TIME_NS = 40;
	localparam int STROBE_HIGH_TIME_NS = 40;
	localparam int DATA_SETUP_TIME_NS = 20;
	localparam int DATA_HOLD_TIME_NS = 10;
	localparam int READ_ENABLE_DELAY_NS = 100;
	localparam int ADDR_DATA_DELAY_NS = 100;
	localparam int STROBE_LOW_CYC =
		(STROBE_LOW_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int STROBE_HIGH_CYC =
		(STROBE_HIGH_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int DATA_HOLD_CYC =
		(DATA_HOLD_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int READ_WAIT_CYC =
		(READ_ENABLE_DELAY_NS + ADDR_DATA_DELAY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int CLEAR_CYC = STROBE_LOW_CYC;
	localparam int CHANNEL_COUNT = 16;
	localparam int DATA_WIDTH = 8;
	localparam int ADDR_WIDTH = 4;
	localparam int COUNT_WIDTH = 8;

	typedef enum logic [2:0] {
		CMD_WRITE = 3'h0,
		CMD_LOAD = 3'h1,
		CMD_WRITE_LOAD = 3'h2,
		CMD_READ = 3'h3,
		CMD_CLEAR = 3'h4
	} cmd_op_t;

	typedef struct packed {
		cmd_op_t op;
		logic [ADDR_WIDTH-1:0] channel;
		logic [DATA_WIDTH-1:0] data;
	} cmd_t;

	// pin bundle driven toward the device, all strobes active low
	typedef struct packed {
		logic [ADDR_WIDTH-1:0] channel_select;
		logic chip_select_n;
		logic read_write;
		logic enable_n;
		logic transfer_strobe_n;
		logic clear_n;
	} ctrl_pins_t;
endpackage : dac_port_pkg

// *** phase_timer.sv ***
// down counter that times one pin phase
`timescale 1ns/1ps
module phase_timer #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// load and status
	input wire logic load,
	input wire logic [WIDTH-1:0] count,
	output logic done
);
	logic [WIDTH-1:0] remain_reg;

	assign done = (remain_reg == '0);

	always_ff @(posedge clock) begin
		if (sys_rst)
			remain_reg <= '0;
		else if (load)
			remain_reg <= count;
		else if (!done)
			remain_reg <= remain_reg - WIDTH'(1);
	end
endmodule : phase_timer

// *** dac_port_host.sv ***
// host controller driving the sixteen channel dac latch port pins
// Operation
// - the host keeps read/write and select low and pulses enable, address changing as enable falls.
// - each enable low plus high phase spans at least 80 ns.
// - each channel is written in its own enable cycle, sixteen for all channels.
// - the host holds select high during a load transfer so no input latch is overwritten.
// - a single channel may be written and then loaded alone.
// - readback sets read/write high, select low, enable and load high, data after the delay.
`timescale 1ns/1ps
module dac_port_host
	import dac_port_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// command port
	input wire logic cmd_valid,
	input dac_port_pkg::cmd_t cmd,
	output logic cmd_ready,
	output logic rd_valid,
	output logic [dac_port_pkg::DATA_WIDTH-1:0] rd_data,
	// device pins
	output dac_port_pkg::ctrl_pins_t pins,
	output logic [dac_port_pkg::DATA_WIDTH-1:0] data_lines_out,
	output logic data_lines_oe,
	input wire logic [dac_port_pkg::DATA_WIDTH-1:0] data_lines_in
);
	import dac_port_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_LOW = 3'h1,
		ST_HIGH = 3'h3,
		ST_LOAD = 3'h2,
		ST_READ = 3'h6,
		ST_CLEAR = 3'h7,
		ST_REST = 3'h5
	} state_t;

	state_t state_reg, state_next;
	cmd_t cur_reg;
	ctrl_pins_t pins_next;
	logic [DATA_WIDTH-1:0] din_meta_reg, din_sync_reg;
	logic [DATA_WIDTH-1:0] drive_next;
	logic oe_next, rd_valid_next;
	logic timer_load, timer_done;
	logic [COUNT_WIDTH-1:0] timer_count;
	logic take;

	// ----------------------------------------------------------------
	// phase timing
	// ----------------------------------------------------------------
	phase_timer #(.WIDTH(COUNT_WIDTH)) phase_timer_inst (
		.clock(clock),
		.sys_rst(sys_rst),
		.load(timer_load),
		.count(timer_count),
		.done(timer_done)
	);

	assign take = cmd_valid && cmd_ready;
	assign timer_load = (state_reg != state_next);

	// ----------------------------------------------------------------
	// next state and pin levels
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		timer_count = COUNT_WIDTH'(STROBE_LOW_CYC - 1);
		case (state_reg)
			ST_IDLE: begin
				if (take) begin
					case (cmd.op)
						CMD_LOAD: state_next = ST_LOAD;
						CMD_READ: state_next = ST_READ;
						CMD_CLEAR: state_next = ST_CLEAR;
						default: state_next = ST_LOW;
					endcase
				end
			end
			ST_LOW: begin
				if (timer_done)
					state_next = ST_HIGH;
				timer_count = COUNT_WIDTH'(STROBE_HIGH_CYC - 1);
			end
			ST_HIGH: begin
				if (timer_done)
					state_next = (cur_reg.op == CMD_WRITE_LOAD) ? ST_LOAD : ST_IDLE;
				timer_count = COUNT_WIDTH'(STROBE_LOW_CYC - 1);
			end
			ST_LOAD: begin
				if (timer_done)
					state_next = ST_REST;
				timer_count = COUNT_WIDTH'(STROBE_HIGH_CYC - 1);
			end
			ST_READ: begin
				if (timer_done)
					state_next = ST_REST;
				timer_count = COUNT_WIDTH'(STROBE_HIGH_CYC - 1);
			end
			ST_CLEAR: begin
				if (timer_done)
					state_next = ST_REST;
				timer_count = COUNT_WIDTH'(STROBE_HIGH_CYC - 1);
			end
			ST_REST: begin
				if (timer_done)
					state_next = ST_IDLE;
			end
			default: state_next = ST_IDLE;
		endcase
		if (state_next == ST_READ)
			timer_count = COUNT_WIDTH'(READ_WAIT_CYC + 1);
		else if (state_next == ST_LOW)
			timer_count = COUNT_WIDTH'(STROBE_LOW_CYC - 1);
		else if (state_next == ST_LOAD || state_next == ST_CLEAR)
			timer_count = COUNT_WIDTH'(CLEAR_CYC - 1);
	end

	cmd_t nxt_cmd;
	assign nxt_cmd = take ? cmd : cur_reg;

	always_comb begin
		pins_next.channel_select = nxt_cmd.channel;
		pins_next.chip_select_n = 1'b1;
		pins_next.read_write = 1'b0;
		pins_next.enable_n = 1'b1;
		pins_next.transfer_strobe_n = 1'b1;
		pins_next.clear_n = 1'b1;
		drive_next = nxt_cmd.data;
		oe_next = 1'b1;
		case (state_next)
			ST_LOW: begin
				pins_next.chip_select_n = 1'b0;
				pins_next.enable_n = 1'b0;
			end
			ST_HIGH: begin
				pins_next.chip_select_n = 1'b0;
			end
			ST_LOAD: begin
				pins_next.enable_n = 1'b0;
				pins_next.transfer_strobe_n = 1'b0;
			end
			ST_READ: begin
				pins_next.chip_select_n = 1'b0;
				pins_next.read_write = 1'b1;
				oe_next = 1'b0;
			end
			ST_CLEAR: begin
				pins_next.clear_n = 1'b0;
			end
			ST_REST: begin
				oe_next = (state_reg != ST_READ);
				pins_next.read_write = (state_reg == ST_READ);
			end
			default: begin
				oe_next = 1'b1;
			end
		endcase
	end

	assign rd_valid_next = (state_reg == ST_READ) && timer_done;

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			din_meta_reg <= '0;
			din_sync_reg <= '0;
		end else begin
			din_meta_reg <= data_lines_in;
			din_sync_reg <= din_meta_reg;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_reg <= ST_IDLE;
			cur_reg <= '0;
			cmd_ready <= 1'b0;
			rd_valid <= 1'b0;
			rd_data <= '0;
			pins <= '{channel_select: '0, chip_select_n: 1'b1, read_write: 1'b0,
				enable_n: 1'b1, transfer_strobe_n: 1'b1, clear_n: 1'b1};
			data_lines_out <= '0;
			data_lines_oe <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (take)
				cur_reg <= cmd;
			cmd_ready <= (state_next == ST_IDLE) && !take;
			rd_valid <= rd_valid_next;
			if (rd_valid_next)
				rd_data <= din_sync_reg;
			pins <= pins_next;
			data_lines_out <= drive_next;
			data_lines_oe <= oe_next;
		end
	end
endmodule : dac_port_host

// *** dac_model.sv ***
// device model: double buffered sixteen channel latch port
`timescale 1ns/1ps
module dac_model (
	// device pins
	input dac_port_pkg::ctrl_pins_t pins,
	input wire logic [7:0] bus_in,
	output logic [7:0] bus_out,
	output logic bus_oe
);
	import dac_port_pkg::*;
	logic [7:0] in_reg [16];
	logic [7:0] dac_reg [16];
	wire rd_on;
	wire [3:0] ch_d;
	wire wr_open = !pins.chip_select_n && !pins.enable_n && !pins.read_write;
	wire ld_open = !pins.transfer_strobe_n && !pins.enable_n;
	wire rd_req = !pins.chip_select_n && pins.read_write && pins.enable_n && pins.transfer_strobe_n;
	assign #(READ_ENABLE_DELAY_NS) rd_on = rd_req;
	assign #(ADDR_DATA_DELAY_NS) ch_d = pins.channel_select;
	assign bus_oe = rd_on && !pins.chip_select_n;
	// released bus shows the inverse, never a stale value
	assign bus_out = bus_oe ? in_reg[ch_d] : ~in_reg[ch_d];
	always @* begin
		for (int i = 0; i < 16; i++) begin
			if (!pins.clear_n) begin
				in_reg[i] = 8'h00;
				dac_reg[i] = 8'h00;
			end else begin
				if (wr_open && pins.channel_select == 4'(i)) in_reg[i] = bus_in;
				if (ld_open) dac_reg[i] = in_reg[i];
			end
		end
	end
endmodule : dac_model

// *** dac_port_host_props.sv ***
// checker: pin sequencing of the dac latch port host
`timescale 1ns/1ps
module dac_port_host_props (
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// command port
	input wire logic cmd_valid,
	input dac_port_pkg::cmd_t cmd,
	input wire logic cmd_ready,
	input wire logic rd_valid,
	input wire logic [dac_port_pkg::DATA_WIDTH-1:0] rd_data,
	// device pins
	input dac_port_pkg::ctrl_pins_t pins,
	input wire logic [dac_port_pkg::DATA_WIDTH-1:0] data_lines_out,
	input wire logic data_lines_oe,
	input wire logic [dac_port_pkg::DATA_WIDTH-1:0] data_lines_in
);
	import dac_port_pkg::*;
	logic [7:0] rd_cnt_reg;
	wire take = cmd_valid && cmd_ready;
	wire reading = !pins.chip_select_n && pins.read_write;
	// read cycles since the last take
	always_ff @(posedge clock)
		if (sys_rst || take) rd_cnt_reg <= 8'h00;
		else if (reading && rd_cnt_reg != 8'hFF) rd_cnt_reg <= rd_cnt_reg + 8'h01;
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	property p_wr; take && cmd.op == CMD_WRITE |=> !pins.chip_select_n && !pins.enable_n
		&& !pins.read_write && pins.channel_select == $past(cmd.channel)
		&& data_lines_out == $past(cmd.data); endproperty
	a_wr: assert property (p_wr) else $error("write pins");
	property p_en_lo; $fell(pins.enable_n) |-> !pins.enable_n [*8]; endproperty
	a_en_lo: assert property (p_en_lo) else $error("enable low short");
	property p_en_hi; $rose(pins.enable_n) |-> pins.enable_n [*8]; endproperty
	a_en_hi: assert property (p_en_hi) else $error("enable high short");
	property p_hold; $rose(pins.enable_n) && !pins.chip_select_n |-> $stable(data_lines_out) [*2];
	endproperty
	a_hold: assert property (p_hold) else $error("data hold");
	property p_ld; take && cmd.op == CMD_LOAD |=> !pins.transfer_strobe_n; endproperty
	a_ld: assert property (p_ld) else $error("load strobe");
	property p_strb; !pins.transfer_strobe_n |-> pins.chip_select_n && !pins.enable_n; endproperty
	a_strb: assert property (p_strb) else $error("strobe qualifiers");
	property p_rd; reading |-> pins.enable_n && pins.transfer_strobe_n && !data_lines_oe; endproperty
	a_rd: assert property (p_rd) else $error("read pins");
	property p_rd_wait; rd_valid |-> rd_cnt_reg >= 8'(READ_WAIT_CYC); endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read too early");
	property p_clr; take && cmd.op == CMD_CLEAR |=> !pins.clear_n; endproperty
	a_clr: assert property (p_clr) else $error("clear pin");
	c_wr: cover property (take && cmd.op == CMD_WRITE);
	c_rd: cover property (rd_valid);
	c_clr: cover property (take && cmd.op == CMD_CLEAR);
endmodule : dac_port_host_props
bind dac_port_host dac_port_host_props dac_port_host_props_inst (.clock(clock),
	.sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
	.rd_valid(rd_valid), .rd_data(rd_data), .pins(pins), .data_lines_out(data_lines_out),
	.data_lines_oe(data_lines_oe), .data_lines_in(data_lines_in));

// *** dac_port_host_tb.sv ***
// testbench: dac latch port host against the device model
`timescale 1ns/1ps
module dac_port_host_tb;
	import dac_port_pkg::*;
	logic clock, sys_rst, cmd_valid, cmd_ready, rd_valid, data_lines_oe, dev_oe;
	cmd_t cmd;
	ctrl_pins_t pins;
	logic [7:0] rd_data, data_lines_out, dev_out, bus;
	int n_mismatch = 0;
	int tests_run = 0;
	int cycles = 0;
	int rd_pulses = 0;
	assign bus = data_lines_oe ? data_lines_out : dev_out;
	// one count per read strobe seen while it stands
	always @(negedge clock)
		if (rd_valid === 1'b1) rd_pulses++;
	// host must have let go whenever the device drives the bus
	always @(negedge clock)
		if (dev_oe === 1'b1) check("bus contention", 8'h00, {7'h00, data_lines_oe});
	dac_port_host dac_port_host_inst (.clock(clock), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
		.cmd(cmd), .cmd_ready(cmd_ready), .rd_valid(rd_valid), .rd_data(rd_data), .pins(pins),
		.data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe), .data_lines_in(bus));
	dac_model dac_model_inst (.pins(pins), .bus_in(bus), .bus_out(dev_out), .bus_oe(dev_oe));
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			n_mismatch++;
			finish_test();
		end
	end
	task automatic finish_test();
		if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : finish_test
	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask : check
	task automatic send(input cmd_op_t op, input logic [3:0] ch, input logic [7:0] d);
		@(negedge clock);
		for (int k = 0; k < 100 && cmd_ready !== 1'b1; k++) @(negedge clock);
		cmd_valid = 1'b1;
		cmd = '{op, ch, d};
		@(negedge clock);
		cmd_valid = 1'b0;
		for (int k = 0; k < 200 && cmd_ready !== 1'b1; k++) @(negedge clock);
	endtask : send
	task automatic t_clear();
		send(CMD_WRITE_LOAD, 4'h3, 8'hA5);
		check("dac3", 8'hA5, dac_model_inst.dac_reg[3]);
		send(CMD_CLEAR, 4'h0, 8'h00);
		check("in3", 8'h00, dac_model_inst.in_reg[3]);
		check("dac3", 8'h00, dac_model_inst.dac_reg[3]);
	endtask : t_clear
	task automatic t_all();
		for (int i = 0; i < 16; i++) send(CMD_WRITE, 4'(i), 8'(i * 15 + 15));
		check("dac0 before load", 8'h00, dac_model_inst.dac_reg[0]);
		send(CMD_LOAD, 4'h0, 8'h00);
		for (int i = 0; i < 16; i++) check("dac", 8'(i * 15 + 15), dac_model_inst.dac_reg[i]);
	endtask : t_all
	task automatic t_single();
		send(CMD_WRITE_LOAD, 4'h9, 8'h5A);
		check("dac9", 8'h5A, dac_model_inst.dac_reg[9]);
		check("dac8", 8'h87, dac_model_inst.dac_reg[8]);
	endtask : t_single
	task automatic t_read(input logic [3:0] ch, input logic [7:0] exp);
		int pulses_before;
		pulses_before = rd_pulses;
		send(CMD_READ, ch, 8'h00);
		check("readback", exp, rd_data);
		check("rd_valid pulses", 8'h01, 8'(rd_pulses - pulses_before));
		check("oe after read", 8'h01, {7'h00, data_lines_oe});
		check("cs after read", 8'h01, {7'h00, pins.chip_select_n});
	endtask : t_read
	initial begin
		sys_rst = 1'b1;
		cmd_valid = 1'b0;
		cmd = '0;
		repeat (10) @(negedge clock);
		sys_rst = 1'b0;
		t_clear();
		t_all();
		t_single();
		t_read(4'h0, 8'h0F);
		t_read(4'h9, 8'h5A);
		t_read(4'hF, 8'hF0);
		finish_test();
	end
endmodule : dac_port_host_tb
